// *** dkl_map.svh ***
// Register offsets, field positions, reset values and key codes of the command decoder.
//
// Function
// R1 - Range codes 0000 to 0011 select voltage ranges; 0000 is the reset default.
// R2 - Range codes 1000 to 1101 select the six current ranges.
// R3 - A write with an undefined range code is ignored; the old range stays.
// R4 - A range change starts a calibration refresh; host waits for the pending flag.
// R5 - Load-update code 0x1DAC updates output when frame select bits match address pins.
// R6 - With broadcast update enabled, frame select bits are ignored for load-update.
// R7 - Readback of load-update and key registers shows zero in bits 15 to 0.
// R8 - Readback bit 21 is the inverted fault pin; bits 20 to 16 the address.
// R9 - Software reset needs key 0x15FA then key 0xAF51, in that order.
// R10 - Key 0x1ADC starts exactly one diagnostic conversion on the selected channel.
// R11 - Key 0x0D06 restarts the watchdog timer count.
// R12 - Key 0xFCBA starts a shadow register refresh from calibration memory.
// R13 - The refresh key works only on its first use after a system reset.
// R14 - The host writes only defined key values; all other values are reserved.
// R15 - A load-update write with any other value has no effect at all.
// R16 - Any key write other than the second key disarms the reset sequence; the code keeps it armed on a repeated first key 0x15FA.
`ifndef DKL_MAP_SVH
`define DKL_MAP_SVH
`define DKL_ADDR_RANGE_REG      5'h06
`define DKL_ADDR_LOAD_UPDATE    5'h07
`define DKL_ADDR_KEY            5'h08
`define DKL_RESET_LOAD_UPDATE   22'h070000
`define DKL_RESET_KEY           22'h080000
`define DKL_RANGE_DEFAULT       4'h0
`define DKL_LOAD_UPDATE_CODE    16'h1dac
`define DKL_KEY_RESET_FIRST     16'h15fa
`define DKL_KEY_RESET_SECOND    16'haf51
`define DKL_KEY_ADC_CONVERT     16'h1adc
`define DKL_KEY_WATCHDOG_KICK   16'h0d06
`define DKL_KEY_CAL_REFRESH     16'hfcba
`define DKL_BIT_FAULT_STATUS    21
`define DKL_FIELD_ADDR_HI       20
`define DKL_FIELD_ADDR_LO       16
`endif

// *** dkl_pkg.sv ***
// Types shared by the command decoder modules.
package dkl_pkg;
    typedef struct packed {
        logic        valid;
        logic [1:0]  dev_sel;
        logic [4:0]  addr;
        logic [15:0] data;
    } dkl_write_type;

    typedef struct packed {
        logic        soft_reset;
        logic        adc_convert;
        logic        watchdog_kick;
        logic        cal_refresh;
    } dkl_key_pulse_type;

    typedef enum logic [1:0] {
        DKL_IDLE  = 2'b00,
        DKL_ARMED = 2'b01
    } dkl_key_state_type;
endpackage : dkl_pkg

// *** dkl_range_decode.sv ***
// Output range code validation and mode decode.
`timescale 1ns/1ps
`include "dkl_map.svh"
module dkl_range_decode
    import dkl_pkg::*;
(
    // Code to check
    input  wire logic [3:0] code,
    // Decode results
    output logic            code_valid,
    output logic            code_is_current
);
    always_comb begin
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3: begin // R1
                code_valid      = 1'b1;
                code_is_current = 1'b0;
            end
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: begin // R2
                code_valid      = 1'b1;
                code_is_current = 1'b1;
            end
            default: begin
                code_valid      = 1'b0;
                code_is_current = 1'b0;
            end
        endcase
    end
endmodule : dkl_range_decode

// *** dkl_key_sequencer.sv ***
// Key register decoder: two-step reset sequence and one-shot key actions.
`timescale 1ns/1ps
`include "dkl_map.svh"
module dkl_key_sequencer
    import dkl_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Key write
    input  wire logic              key_write,
    input  wire logic [15:0]       key_value,
    // Action pulses
    output dkl_key_pulse_type      pulses
);
    dkl_key_state_type state;
    dkl_key_state_type next_state;
    logic              refresh_used;

    always_comb begin
        next_state = state;
        if (key_write) begin
            if (key_value == `DKL_KEY_RESET_FIRST) begin // R9
                next_state = DKL_ARMED;
            end else begin
                next_state = DKL_IDLE; // R16
            end
        end
        case (state)
            DKL_IDLE:  ;
            DKL_ARMED: ;
            default:   next_state = DKL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DKL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_used <= 1'b0;
        end else if (key_write && key_value == `DKL_KEY_CAL_REFRESH) begin
            refresh_used <= 1'b1; // R13
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulses <= '0;
        end else begin
            pulses.soft_reset    <= key_write && state == DKL_ARMED
                                    && key_value == `DKL_KEY_RESET_SECOND; // R9
            pulses.adc_convert   <= key_write && key_value == `DKL_KEY_ADC_CONVERT; // R10
            pulses.watchdog_kick <= key_write && key_value == `DKL_KEY_WATCHDOG_KICK; // R11
            pulses.cal_refresh   <= key_write && !refresh_used
                                    && key_value == `DKL_KEY_CAL_REFRESH; // R12 R13
        end
    end

    // The two steps of the reset sequence, each a single key register write.
    sequence s_first_key;
        key_write && key_value == `DKL_KEY_RESET_FIRST;
    endsequence

    sequence s_second_key;
        key_write && key_value == `DKL_KEY_RESET_SECOND;
    endsequence

    a_reset_needs_arm: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        pulses.soft_reset |-> $past(state) == DKL_ARMED)
        else $error("soft reset without armed first key");
    a_reset_sequence: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        s_first_key ##1 s_second_key |=> pulses.soft_reset)
        else $error("key pair did not reset");
    a_reset_after_gap: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9 R16
        state == DKL_ARMED && key_write && key_value == `DKL_KEY_RESET_SECOND
        |=> pulses.soft_reset)
        else $error("armed second key did not reset");
    a_disarm_other: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
        key_write && key_value != `DKL_KEY_RESET_FIRST |=> state == DKL_IDLE)
        else $error("sequence stayed armed");
    a_adc_one_shot: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        pulses.adc_convert |-> $past(key_write && key_value == `DKL_KEY_ADC_CONVERT))
        else $error("adc pulse without key");
    a_wdt_kick: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        key_write && key_value == `DKL_KEY_WATCHDOG_KICK |=> pulses.watchdog_kick)
        else $error("watchdog kick missing");
    a_refresh_once: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
        refresh_used && key_write && key_value == `DKL_KEY_CAL_REFRESH
        |=> !pulses.cal_refresh)
        else $error("refresh key acted twice");
endmodule : dkl_key_sequencer

// *** dkl_command_decoder.sv ***
// Range, load-update and key command decoder with register readback.
`timescale 1ns/1ps
`include "dkl_map.svh"
module dkl_command_decoder
    import dkl_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Decoded serial frame write
    input  wire dkl_write_type     frame_write,
    // Readback request
    input  wire logic [4:0]        read_addr,
    output logic [21:0]            read_data,
    // Device configuration and pins
    input  wire logic              device_select_pin_high,
    input  wire logic              device_select_pin_low,
    input  wire logic              broadcast_update_enable,
    input  wire logic              fault_pin,
    input  wire logic              cal_refresh_done,
    // Outputs to the rest of the device
    output logic [3:0]             output_range,
    output logic                   range_is_current,
    output logic                   calibration_pending_flag,
    output logic                   load_update,
    output logic                   soft_reset,
    output logic                   adc_convert,
    output logic                   watchdog_kick,
    output logic                   cal_refresh_start
);
    logic              rst_meta;
    logic              rst_sync_n;
    logic              code_valid;
    logic              code_is_current;
    logic              range_write;
    logic              key_write;
    logic              range_change;
    logic              key_refresh;
    logic              refresh_seen;
    dkl_key_pulse_type pulses;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign range_write = frame_write.valid && frame_write.addr == `DKL_ADDR_RANGE_REG;
    assign key_write   = frame_write.valid && frame_write.addr == `DKL_ADDR_KEY;

    dkl_range_decode u_range (
        .code            (frame_write.data[3:0]),
        .code_valid      (code_valid),
        .code_is_current (code_is_current)
    );

    assign range_change = range_write && code_valid
                          && frame_write.data[3:0] != output_range;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            output_range     <= `DKL_RANGE_DEFAULT;
            range_is_current <= 1'b0;
        end else if (range_write && code_valid) begin // R1 R2 R3
            output_range     <= frame_write.data[3:0];
            range_is_current <= code_is_current;
        end
    end

    // A start request wins over the completion seen in the same cycle.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            calibration_pending_flag <= 1'b0;
        end else if (range_change || key_refresh) begin
            calibration_pending_flag <= 1'b1; // R4
        end else if (cal_refresh_done) begin
            calibration_pending_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            load_update <= 1'b0;
        end else begin
            load_update <= frame_write.valid
                           && frame_write.addr == `DKL_ADDR_LOAD_UPDATE
                           && frame_write.data == `DKL_LOAD_UPDATE_CODE // R15
                           && (broadcast_update_enable // R6
                               || frame_write.dev_sel == {device_select_pin_high,
                                                          device_select_pin_low}); // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    dkl_key_sequencer u_keys (
        .sys_clk   (sys_clk),
        .rst_n     (rst_sync_n),
        .key_write (key_write),
        .key_value (frame_write.data),
        .pulses    (pulses)
    );

    // Local copy of the one-shot refresh memory, so pending rises with the key write itself.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            refresh_seen <= 1'b0;
        end else if (key_write && frame_write.data == `DKL_KEY_CAL_REFRESH) begin
            refresh_seen <= 1'b1; // R13
        end
    end

    assign key_refresh       = key_write && frame_write.data == `DKL_KEY_CAL_REFRESH
                               && !refresh_seen; // R12
    assign soft_reset        = pulses.soft_reset;
    assign adc_convert       = pulses.adc_convert;
    assign watchdog_kick     = pulses.watchdog_kick;
    assign cal_refresh_start = pulses.cal_refresh;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            read_data <= '0;
        end else begin
            read_data <= '0; // R7
            read_data[`DKL_BIT_FAULT_STATUS] <= ~fault_pin; // R8
            read_data[`DKL_FIELD_ADDR_HI:`DKL_FIELD_ADDR_LO] <= read_addr; // R8
            if (read_addr == `DKL_ADDR_RANGE_REG) begin
                read_data[3:0] <= output_range;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_bad_range_kept: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R3
        range_write && !code_valid |=> $stable(output_range))
        else $error("undefined range code was taken");
    a_range_pending: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R4
        range_change |=> calibration_pending_flag)
        else $error("range change did not raise pending");
    a_update_match: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R15
        load_update |-> $past(frame_write.data) == `DKL_LOAD_UPDATE_CODE)
        else $error("update without code");
    a_update_addr: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R5
        load_update && !$past(broadcast_update_enable) |->
        $past(frame_write.dev_sel) == $past({device_select_pin_high,
                                             device_select_pin_low}))
        else $error("update for another device");
    a_broadcast: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R6
        frame_write.valid && frame_write.addr == `DKL_ADDR_LOAD_UPDATE
        && frame_write.data == `DKL_LOAD_UPDATE_CODE && broadcast_update_enable
        |=> load_update)
        else $error("broadcast update missed");
    a_read_fault: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R8
        ##1 read_data[21] == !$past(fault_pin))
        else $error("fault status not inverted");
    a_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R7
        $past(read_addr) inside {`DKL_ADDR_LOAD_UPDATE, `DKL_ADDR_KEY}
        |-> read_data[15:0] == 16'h0000)
        else $error("command register read not zero");
endmodule : dkl_command_decoder

// *** dkl_host_model.sv ***
// Host model that issues register frames and readback requests to the decoder.
`timescale 1ns/1ps
module dkl_host_model
    import dkl_pkg::*;
(
    // Clock
    input  wire logic          sys_clk,
    // Frame and readback
    output dkl_write_type      frame_write,
    output logic [4:0]         read_addr,
    input  wire logic [21:0]   read_data,
    // Status
    input  wire logic          calibration_pending_flag,
    output logic               hang
);
    initial begin
        frame_write = '0;
        read_addr   = 5'h00;
        hang        = 1'b0;
    end

    // Sends one frame, then holds off until the calibration refresh has finished.
    task automatic wr(input logic [1:0] s, input logic [4:0] a, input logic [15:0] d);
        int n;
        @(negedge sys_clk);
        frame_write = '{1'b1, s, a, d};
        @(negedge sys_clk);
        frame_write.valid = 1'b0;
        frame_write.data  = ~d;
        repeat (2) @(negedge sys_clk);
        n = 0;
        while (calibration_pending_flag === 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 50) hang = 1'b1;
    endtask : wr

    // Two frames to one register in consecutive cycles, valid held high across both.
    task automatic wr_pair(input logic [4:0] a, input logic [15:0] d0, input logic [15:0] d1);
        @(negedge sys_clk);
        frame_write = '{1'b1, 2'b00, a, d0};
        @(negedge sys_clk);
        frame_write.data = d1;
        @(negedge sys_clk);
        frame_write.valid = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : wr_pair

    task automatic rd(input logic [4:0] a, output logic [21:0] d);
        @(negedge sys_clk);
        read_addr = a;
        repeat (2) @(negedge sys_clk);
        d = read_data;
    endtask : rd
endmodule : dkl_host_model

// *** testbench.sv ***
// Self-checking testbench for the command decoder.
`timescale 1ns/1ps
`include "dkl_map.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
    import dkl_pkg::*;
    logic          sys_clk, rst_n, fault_pin, cal_refresh_done, hang, pend_seen;
    logic          device_select_pin_high, device_select_pin_low, broadcast_update_enable;
    dkl_write_type frame_write;
    logic [4:0]    read_addr, pv;
    logic [21:0]   read_data, rv;
    logic [3:0]    output_range, exp_range;
    logic          range_is_current, calibration_pending_flag, load_update, soft_reset;
    logic          adc_convert, watchdog_kick, cal_refresh_start;
    int            bad_count, checks, cc;
    int            cnt [5];

    dkl_command_decoder dut (.sys_clk, .rst_n, .frame_write, .read_addr, .read_data,
        .device_select_pin_high, .device_select_pin_low, .broadcast_update_enable,
        .fault_pin, .cal_refresh_done, .output_range, .range_is_current,
        .calibration_pending_flag, .load_update, .soft_reset, .adc_convert,
        .watchdog_kick, .cal_refresh_start);
    dkl_host_model host (.sys_clk, .frame_write, .read_addr, .read_data,
        .calibration_pending_flag, .hang);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration engine answers a pending refresh after three cycles.
    assign pv = {load_update, soft_reset, adc_convert, watchdog_kick, cal_refresh_start};
    always @(negedge sys_clk) begin
        cal_refresh_done <= 1'b0;
        if (calibration_pending_flag === 1'b1) begin
            cc++;
            pend_seen = 1'b1;
            if (cc == 3) cal_refresh_done <= 1'b1;
        end else cc = 0;
        foreach (cnt[i]) if (pv[i] === 1'b1) cnt[i]++;
    end

    always @(posedge hang) begin
        bad_count++;
        final_report();
    end

    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // One write, then a count of each action pulse against the expected set.
    task automatic op(input logic [1:0] s, input logic [4:0] a, input logic [15:0] d,
                      input logic [4:0] e);
        foreach (cnt[i]) cnt[i] = 0;
        host.wr(s, a, d);
        foreach (cnt[i]) `CHK(cnt[i], int'(e[i]))
    endtask : op

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        device_select_pin_high = 1'b1;
        device_select_pin_low = 1'b0;
        broadcast_update_enable = 1'b0;
        fault_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK(output_range, `DKL_RANGE_DEFAULT)
        for (int a = 7; a <= 8; a++) begin
            fault_pin = 1'b1;
            host.rd(5'(a), rv);
            `CHK(rv, {1'b0, 5'(a), 16'h0000})
            fault_pin = 1'b0;
            host.rd(5'(a), rv);
            `CHK(rv, {1'b1, 5'(a), 16'h0000})
        end
        exp_range = 4'h0;
        for (int c = 15; c >= 0; c--) begin
            pend_seen = 1'b0;
            host.wr(2'b00, `DKL_ADDR_RANGE_REG, 16'(c));
            `CHK(pend_seen, 1'((c inside {[0:3], [8:13]}) && 4'(c) != exp_range))
            if (c inside {[0:3], [8:13]}) exp_range = 4'(c);
            `CHK(output_range, exp_range)
            `CHK(range_is_current, exp_range[3])
        end
        host.wr(2'b00, `DKL_ADDR_RANGE_REG, 16'h0009);
        host.rd(`DKL_ADDR_RANGE_REG, rv);
        `CHK(rv, {1'b1, `DKL_ADDR_RANGE_REG, 12'h000, 4'h9})
        op(2'b10, 5'h07, 16'h1dac, 5'b10000);
        op(2'b01, 5'h07, 16'h1dac, 5'b00000);
        op(2'b10, 5'h07, 16'h1dad, 5'b00000);
        device_select_pin_high = 1'b0;
        device_select_pin_low = 1'b1;
        op(2'b01, 5'h07, 16'h1dac, 5'b10000);
        broadcast_update_enable = 1'b1;
        op(2'b10, 5'h07, 16'h1dac, 5'b10000);
        op(2'b11, 5'h07, 16'h0000, 5'b00000);
        broadcast_update_enable = 1'b0;
        host.rd(5'h07, rv);
        `CHK(rv[15:0], 16'h0000)
        op(2'b00, 5'h08, 16'h1adc, 5'b00100);
        op(2'b00, 5'h08, 16'h0d06, 5'b00010);
        op(2'b00, 5'h08, 16'hfcba, 5'b00001);
        op(2'b00, 5'h08, 16'hfcba, 5'b00000);
        op(2'b00, 5'h08, 16'haf51, 5'b00000);
        op(2'b00, 5'h08, 16'h15fa, 5'b00000);
        op(2'b00, 5'h08, 16'h0d06, 5'b00010);
        op(2'b00, 5'h08, 16'haf51, 5'b00000);
        op(2'b00, 5'h08, 16'h15fa, 5'b00000);
        op(2'b00, 5'h08, 16'haf51, 5'b01000);
        foreach (cnt[i]) cnt[i] = 0;
        host.wr_pair(5'h08, 16'h15fa, 16'haf51);
        `CHK(cnt[3], 1)
        host.rd(5'h08, rv);
        `CHK(rv[15:0], 16'h0000)
        final_report();
    end
endmodule : testbench
